// *** stp_fabric_src.sv ***
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// fabric-side word source
// ****************************************************************
module stp_fabric_src (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	// fabric data
	output logic      [19:0] TX_DATA,
	output logic      [1:0]  TX_KCTRL,
	output logic             TX_VALID,
	input  wire logic        TX_READY
);
	logic [21:0] q_r [$];

	// words are offered strictly in the order they were queued
	task automatic put(input logic [19:0] d, input logic [1:0] k);
		q_r.push_back({k, d});
	endtask

	initial begin
		TX_DATA  = 20'h0;
		TX_KCTRL = 2'h0;
		TX_VALID = 1'b0;
	end

	// runs on the reference clock itself: no rate offset, phase well inside one period
	always @(posedge SYS_CLK) begin
		if (SRST) begin
			q_r.delete();
			TX_VALID <= 1'b0;
		end else begin
			if (TX_VALID && TX_READY)
				void'(q_r.pop_front());
			if (q_r.size() != 0) begin
				TX_VALID <= 1'b1;
				{TX_KCTRL, TX_DATA} <= q_r[0];
			end else begin
				// idle bus shows junk so a stale word never passes for data
				TX_VALID <= 1'b0;
				TX_DATA  <= ~TX_DATA;
			end
		end
	end
endmodule

`default_nettype wire

// *** stp_pkg.sv ***
package stp_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [3:0]  STP_OFS_CTRL      = 4'h0;
	localparam logic [3:0]  STP_OFS_STAT      = 4'h4;
	localparam int          STP_CTRL_CHAN_EN  = 0;
	localparam int          STP_CTRL_DBL      = 1;
	localparam int          STP_CTRL_ENC_BYP  = 2;
	localparam int          STP_CTRL_W10      = 3;
	localparam int          STP_CTRL_PROTO    = 4;
	localparam int          STP_CTRL_GIGE_DIS = 6;
	localparam int          STP_CTRL_PREDIV   = 7;
	localparam int          STP_CTRL_MULT     = 8;
	localparam int          STP_STAT_LOCK     = 0;
	localparam int          STP_STAT_MULT_ERR = 1;
	localparam int          STP_STAT_RD       = 2;
	localparam int          STP_STAT_UFLOW    = 3;
	localparam int          STP_STAT_LEVEL    = 4;
	localparam logic [4:0]  STP_MULT_RST      = 5'h0a;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int          STP_CLK_MHZ       = 10;
	localparam int          STP_LOCK_NS       = 2000;
	localparam int          STP_LOCK_CYC      = (STP_LOCK_NS * STP_CLK_MHZ + 999) / 1000;
	localparam int          STP_A_MIN         = 16;

	// ****************************************************************
	// characters (byte value of the code group), then the K28 6b and A7 4b sub-block codes
	// ****************************************************************
	localparam logic [7:0]  STP_K28_0 = 8'h1c;
	localparam logic [7:0]  STP_K28_3 = 8'h7c;
	localparam logic [7:0]  STP_K28_4 = 8'h9c;
	localparam logic [7:0]  STP_K28_5 = 8'hbc;
	localparam logic [7:0]  STP_K27_7 = 8'hfb;
	localparam logic [7:0]  STP_K29_7 = 8'hfd;
	localparam logic [7:0]  STP_K30_7 = 8'hfe;
	localparam logic [7:0]  STP_XG_IDLE = 8'h07;
	localparam logic [7:0]  STP_D21_5 = 8'hb5;
	localparam logic [7:0]  STP_D2_2  = 8'h42;
	localparam logic [7:0]  STP_D5_6  = 8'hc5;
	localparam logic [7:0]  STP_D16_2 = 8'h50;
	localparam logic [5:0]  STP_K28_6B = 6'h0f;
	localparam logic [3:0]  STP_A7_4B  = 4'h7;

	// 5b/6b and 3b/4b codes for negative running disparity, a / f as msb
	localparam logic [5:0]  STP_T6 [0:31] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
		6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0]  STP_T4 [0:7] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

	typedef enum logic [1:0] {STP_BASIC = 2'b00, STP_GIGE = 2'b01, STP_XAUI = 2'b10} stp_proto_t;
	typedef enum logic [1:0] {SM_NORM = 2'b00, SM_GIGE_K = 2'b01, SM_XAUI_T = 2'b10} stp_sm_t;

endpackage

// *** stp_tx_pcs.sv ***
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - pll gives bit, training and fabric clocks
// - pll off when channel unused
// - pll lock indication output
// - factors 2,4,5,8,10,16,20; 2,5 need prediv
// - four word fifo always in path
// - double width split into two words
// - single width bypasses byte serializer
// - byte plus flag to 10b, bypassable
// - run length never above five while the encoder is on
// - state machine follows xaui or gige
// - gige idles become I1 or I2
// - I1 K28.5+ D5.6, I2 K28.5- D16.2+
// - configuration sets left untouched
// - disparity negative after I1 or I2
// - gige machine statically disableable
// - xaui data byte to data group
// - xaui control characters translated
// - prbs7 picks R or K idles
// - A inserted every 16 to 31 idles
// - serializer sends lsb first
module stp_tx_pcs #(
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	// register port
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	// fabric data
	input  wire logic [19:0] TX_DATA,
	input  wire logic [1:0]  TX_KCTRL,
	input  wire logic        TX_VALID,
	output logic             TX_READY,
	// serial line and clocks
	output logic             TX_SERIAL,
	output logic             HS_CLK_EN,
	output logic             RX_TRAIN_CLK,
	output logic             FABRIC_CLK,
	output logic             PLL_LOCKED
);
	import stp_pkg::*;

	// ****************************************************************
	// functions
	// ****************************************************************
	// returns {running disparity after, code j..a with a in bit 0}
	function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k, input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic       k28;
		logic       rd_mid;
		logic       a7;
		logic       unb4;
		logic [9:0] o;
		k28 = k && (d[4:0] == 5'd28);
		c6 = k28 ? STP_K28_6B : STP_T6[d[4:0]];
		if (rd && (($countones(c6) != 3) || (d[4:0] == 5'd7))) begin
			c6 = ~c6;
		end
		rd_mid = rd ^ ($countones(c6) != 3);
		a7 = (d[7:5] == 3'd7) && (k || (!rd_mid && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20))
			|| (rd_mid && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14)));
		c4 = a7 ? STP_A7_4B : STP_T4[d[7:5]];
		unb4 = ($countones(c4) != 2) || (d[7:5] == 3'd3);
		if (k28 ? (unb4 ? rd_mid : !rd_mid) : (unb4 && rd_mid)) begin
			c4 = ~c4;
		end
		for (int i = 0; i < 6; i++) begin
			o[i] = c6[5-i];
		end
		for (int i = 0; i < 4; i++) begin
			o[6+i] = c4[3-i];
		end
		return {rd_mid ^ ($countones(c4) != 2), o};
	endfunction

	// allowed multiplication factors, 2 and 5 only behind the pre-divider
	function automatic logic mult_ok(input logic [4:0] m, input logic prediv);
		case (m)
			5'd4, 5'd8, 5'd10, 5'd16, 5'd20: begin
				mult_ok = 1'b1;
			end
			5'd2, 5'd5: begin
				mult_ok = prediv;
			end
			default: begin
				mult_ok = 1'b0;
			end
		endcase
	endfunction

	// ****************************************************************
	// registers and state
	// ****************************************************************
	logic [12:0]             ctrl_r;
	logic                    uflow_r;
	logic [31:0]             rdata_r;
	logic [$clog2(STP_LOCK_CYC+1)-1:0] lock_cnt_r;
	logic [19:0]             mem_r [DEPTH];
	logic [1:0]              memk_r [DEPTH];
	logic [$clog2(DEPTH)-1:0] wp_r;
	logic [$clog2(DEPTH)-1:0] rp_r;
	logic [$clog2(DEPTH):0]  cnt_r;
	logic                    half_r;
	logic                    run_r;
	logic [3:0]              bit_r;
	logic [9:0]              sh_r;
	logic                    rd_r;
	stp_sm_t                 sm_r;
	logic                    i1_r;
	logic [6:0]              prbs_r;
	logic [4:0]              acnt_r;
	logic                    train_r;
	logic                    fab_r;

	// ****************************************************************
	// configuration decode
	// ****************************************************************
	wire logic       chan_en   = ctrl_r[STP_CTRL_CHAN_EN];
	wire logic       dbl       = ctrl_r[STP_CTRL_DBL];
	wire logic       enc_on    = !ctrl_r[STP_CTRL_ENC_BYP];
	wire logic       w10       = ctrl_r[STP_CTRL_W10];
	wire stp_proto_t proto     = stp_proto_t'(ctrl_r[STP_CTRL_PROTO +: 2]);
	wire logic       gige_on   = (proto == STP_GIGE) && !ctrl_r[STP_CTRL_GIGE_DIS];
	wire logic       xaui_on   = (proto == STP_XAUI);
	wire logic       mult_bad  = !mult_ok(ctrl_r[STP_CTRL_MULT +: 5], ctrl_r[STP_CTRL_PREDIV]);
	wire logic       ctrl_wr   = REG_WR && (REG_ADDR == STP_OFS_CTRL);
	wire logic       stat_wr   = REG_WR && (REG_ADDR == STP_OFS_STAT);
	wire logic [3:0] sym_last  = (enc_on || w10) ? 4'd9 : 4'd7;

	// ****************************************************************
	// fifo and byte serializer selection
	// ****************************************************************
	wire logic        locked  = (lock_cnt_r == STP_LOCK_CYC[$bits(lock_cnt_r)-1:0]);
	wire logic        empty   = (cnt_r == '0);
	wire logic        full    = (cnt_r == DEPTH[$clog2(DEPTH):0]);
	wire logic        load    = locked && (!run_r || (bit_r == sym_last));
	wire logic        push    = TX_VALID && !full;
	wire logic        pop     = load && !empty && (!dbl || half_r);
	wire logic [19:0] head    = mem_r[rp_r];
	wire logic [1:0]  headk   = memk_r[rp_r];
	// an empty fifo sends a comma (or an xgmii idle), or an all-zero word with the encoder bypassed, rather than stale data
	wire logic [7:0]  in_byte = empty ? (xaui_on ? STP_XG_IDLE : STP_K28_5) : (half_r ? head[15:8] : head[7:0]);
	wire logic        in_k    = empty ? 1'b1 : (half_r ? headk[1] : headk[0]);
	wire logic [9:0]  in_raw  = empty ? 10'h000 : (half_r ? head[19:10] : head[9:0]);

	// ****************************************************************
	// transmit state machine
	// ****************************************************************
	logic [7:0] sm_byte;
	logic       sm_k;
	logic       idle_rep;
	logic       a_emit;
	logic       xg_idle;
	stp_sm_t    sm_nxt;
	always_comb begin
		sm_byte = in_byte;
		sm_k = in_k;
		idle_rep = 1'b0;
		a_emit = 1'b0;
		xg_idle = 1'b0;
		sm_nxt = SM_NORM;
		if (gige_on) begin
			// second byte of an idle set; configuration sets pass
			if (sm_r == SM_GIGE_K && !in_k && in_byte != STP_D21_5 && in_byte != STP_D2_2) begin
				sm_byte = i1_r ? STP_D5_6 : STP_D16_2;
				idle_rep = 1'b1;
			end
			if (in_k && in_byte == STP_K28_5) begin
				sm_nxt = SM_GIGE_K;
			end
		end else if (xaui_on && in_k) begin
			case (in_byte)
				STP_XG_IDLE: begin
					xg_idle = 1'b1;
					if (sm_r == SM_XAUI_T) begin
						sm_byte = STP_K28_5;
					end else if (acnt_r == 5'd0) begin
						sm_byte = STP_K28_3;
						a_emit = 1'b1;
					end else begin
						sm_byte = prbs_r[0] ? STP_K28_0 : STP_K28_5;
					end
				end
				STP_K28_4, STP_K27_7, STP_K29_7, STP_K30_7, 8'h3c, 8'h5c, 8'hdc, 8'hf7: begin
					sm_byte = in_byte;
				end
				default: begin
					sm_byte = STP_K30_7;
				end
			endcase
			if (in_byte == STP_K29_7) begin
				sm_nxt = SM_XAUI_T;
			end
		end
	end

	// xaui data lanes (control bit low) fall through unchanged above; gige idle second bytes are replaced
	wire logic [10:0] enc_out = enc8b10b(sm_byte, sm_k, rd_r);
	wire logic [9:0]  code    = enc_on ? enc_out[9:0] : in_raw;

	// ****************************************************************
	// register port
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			ctrl_r <= {STP_MULT_RST, 8'h00};
		end else if (ctrl_wr) begin
			ctrl_r <= REG_WDATA[12:0];
		end
	end

	// underflow is sticky; write one to clear, a new event wins
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			uflow_r <= 1'b0;
		end else begin
			uflow_r <= (load && empty) || (uflow_r && !(stat_wr && REG_WDATA[STP_STAT_UFLOW]));
		end
	end

	wire logic [31:0] stat_word = {25'h0, cnt_r, uflow_r, rd_r, mult_bad, locked};
	wire logic [31:0] rd_mux    = (REG_ADDR == STP_OFS_CTRL) ? {19'h0, ctrl_r} :
		(REG_ADDR == STP_OFS_STAT) ? stat_word : 32'h0;
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			rdata_r <= 32'h0;
		end else begin
			rdata_r <= REG_RD ? rd_mux : 32'h0;
		end
	end

	// ****************************************************************
	// pll model
	// ****************************************************************
	// reconfiguration restarts acquisition; off when channel unused
	always_ff @(posedge SYS_CLK) begin
		if (SRST || ctrl_wr || !chan_en || mult_bad) begin
			lock_cnt_r <= '0;
		end else if (!locked) begin
			lock_cnt_r <= lock_cnt_r + 1'b1;
		end
	end

	// ****************************************************************
	// phase compensation fifo
	// ****************************************************************
	// no bypass path exists: every word goes through these entries
	always_ff @(posedge SYS_CLK) begin
		if (push) begin
			mem_r[wp_r] <= TX_DATA;
			memk_r[wp_r] <= TX_KCTRL;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= push ? wp_r + 1'b1 : wp_r;
			rp_r <= pop ? rp_r + 1'b1 : rp_r;
			cnt_r <= cnt_r + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
		end
	end

	// ****************************************************************
	// byte serializer, state machine and encoder state
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			half_r <= 1'b0;
			rd_r <= 1'b0;
			sm_r <= SM_NORM;
			i1_r <= 1'b0;
			prbs_r <= 7'h7f;
			acnt_r <= 5'd16;
		end else if (load) begin
			half_r <= (dbl && !empty) ? !half_r : 1'b0;
			rd_r <= enc_on ? enc_out[10] : rd_r;
			sm_r <= sm_nxt;
			i1_r <= rd_r;
			if (xg_idle) begin
				prbs_r <= {prbs_r[5:0], prbs_r[6] ^ prbs_r[5]};
				acnt_r <= a_emit ? 5'(STP_A_MIN) + {1'b0, prbs_r[3:0]} :
					(acnt_r == 5'd0 ? acnt_r : acnt_r - 5'd1);
			end
		end
	end

	// ****************************************************************
	// serializer and clock outputs
	// ****************************************************************
	// the bit clock is the system clock; the shift stops while unlocked
	always_ff @(posedge SYS_CLK) begin
		if (SRST || !locked) begin
			run_r <= 1'b0;
			bit_r <= 4'd0;
			sh_r <= 10'h000;
		end else if (load) begin
			run_r <= 1'b1;
			bit_r <= 4'd0;
			sh_r <= code;
		end else begin
			bit_r <= bit_r + 4'd1;
			sh_r <= {1'b0, sh_r[9:1]};
		end
	end

	// training clock at word rate; fabric clock toggles per symbol in double width so underflow never stops it
	always_ff @(posedge SYS_CLK) begin
		if (SRST || !locked) begin
			train_r <= 1'b0;
			fab_r <= 1'b0;
		end else begin
			train_r <= load || (run_r && bit_r < {1'b0, sym_last[3:1]});
			fab_r <= dbl ? (load ? !fab_r : fab_r) : (load || (run_r && bit_r < {1'b0, sym_last[3:1]}));
		end
	end

	assign TX_SERIAL    = sh_r[0];
	assign HS_CLK_EN    = run_r;
	assign RX_TRAIN_CLK = train_r;
	assign FABRIC_CLK   = fab_r;
	assign PLL_LOCKED   = locked;
	assign TX_READY     = !full;
	assign REG_RDATA    = rdata_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	// helpers: serial run length, idle count since the last A
	logic [3:0] runl_r;
	logic [5:0] idles_r;
	logic       prev_r;
	always_ff @(posedge SYS_CLK) begin
		if (SRST || !run_r || !enc_on || ctrl_wr) begin
			runl_r <= 4'd0;
			prev_r <= 1'b0;
		end else begin
			prev_r <= TX_SERIAL;
			runl_r <= (runl_r != 4'd0 && TX_SERIAL == prev_r) ? runl_r + 4'd1 : 4'd1;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin // same restart as the A counter it shadows
			idles_r <= 6'd0;
		end else if (load && xg_idle) begin
			idles_r <= a_emit ? 6'd0 : idles_r + 6'd1;
		end
	end

	property p_fifo_depth;
		@(posedge SYS_CLK) disable iff (SRST) (cnt_r <= DEPTH) && (TX_READY == (cnt_r != DEPTH));
	endproperty
	a_fifo_depth: assert property (p_fifo_depth) else $error("fifo level beyond depth");

	property p_lsb_first;
		@(posedge SYS_CLK) disable iff (SRST) (load && !ctrl_wr) |=> ##1 (TX_SERIAL == $past(code[1], 2));
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("second bit out is not code bit 1");

	property p_run_length;
		@(posedge SYS_CLK) disable iff (SRST) runl_r <= 4'd5;
	endproperty
	a_run_length: assert property (p_run_length) else $error("more than five equal bits");

	property p_idle_rd;
		@(posedge SYS_CLK) disable iff (SRST) (load && idle_rep && enc_on) |=> !rd_r;
	endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("disparity positive after idle set");

	property p_a_interval;
		@(posedge SYS_CLK) disable iff (SRST || ctrl_wr) (load && a_emit) |-> (idles_r >= 6'd16 && idles_r <= 6'd31);
	endproperty
	a_a_interval: assert property (p_a_interval) else $error("A spacing outside 16 to 31");

	property p_prbs_live;
		@(posedge SYS_CLK) disable iff (SRST) (load && xg_idle) |=> (prbs_r != 7'h00) && (prbs_r != $past(prbs_r));
	endproperty
	a_prbs_live: assert property (p_prbs_live) else $error("idle prbs stuck");

	property p_single_bypass;
		@(posedge SYS_CLK) disable iff (SRST) (!dbl && load) |=> !half_r;
	endproperty
	a_single_bypass: assert property (p_single_bypass) else $error("byte serializer active in single width");

	property p_dbl_pop;
		@(posedge SYS_CLK) disable iff (SRST) (dbl && load && !empty && !half_r) |-> !pop ##1 half_r;
	endproperty
	a_dbl_pop: assert property (p_dbl_pop) else $error("double word popped after one half");

	property p_pll_off;
		@(posedge SYS_CLK) disable iff (SRST) (!chan_en || mult_bad) |=> !PLL_LOCKED;
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("pll locked while off or misconfigured");

	property p_cfg_pass;
		@(posedge SYS_CLK) disable iff (SRST) (gige_on && sm_r == SM_GIGE_K && !in_k && in_byte == STP_D21_5)
			|-> (sm_byte == STP_D21_5);
	endproperty
	a_cfg_pass: assert property (p_cfg_pass) else $error("configuration set altered");

	c_i1: cover property (@(posedge SYS_CLK) load && idle_rep && i1_r);
	c_i2: cover property (@(posedge SYS_CLK) load && idle_rep && !i1_r);
	c_a: cover property (@(posedge SYS_CLK) load && a_emit);
	c_full: cover property (@(posedge SYS_CLK) full && TX_VALID);
endmodule

`default_nettype wire

// *** stp_tx_pcs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module stp_tx_pcs_tb;
	import stp_pkg::*;

	// ****************************************************************
	// signals and code groups (a transmitted first, leftmost)
	// ****************************************************************
	logic        SYS_CLK   = 1'b0;
	logic        SRST      = 1'b1;
	logic [3:0]  REG_ADDR  = 4'h0;
	logic [31:0] REG_WDATA = 32'h0;
	logic        REG_WR    = 1'b0;
	logic        REG_RD    = 1'b0;
	logic [31:0] REG_RDATA;
	logic [19:0] TX_DATA;
	logic [1:0]  TX_KCTRL;
	logic        TX_VALID, TX_READY, TX_SERIAL, HS_CLK_EN, RX_TRAIN_CLK, FABRIC_CLK, PLL_LOCKED;
	int          num_errors = 0;
	int          checked    = 0;
	logic        bq [$];
	logic [31:0] rv;
	int          ml [8] = '{2, 3, 4, 5, 8, 10, 16, 20};
	logic [9:0]  wd [6] = '{10'h3a5, 10'h0f1, 10'h2c7, 10'h155, 10'h38e, 10'h063};
	logic [7:0]  gd [8] = '{8'hbc, 8'h00, 8'hbc, 8'h00, 8'hbc, 8'hb5, 8'hbc, 8'h00};
	int          fr, tr, st, gap, na;
	bit          ok;
	localparam logic [9:0] KN = 10'b0011111010, KP = 10'b1100000101, AN = 10'b0011110011;
	localparam logic [9:0] AP = 10'b1100001100, RN = 10'b0011110100, RP = 10'b1100001011;
	localparam logic [19:0] I1 = {KP, 10'b1010010110}, I2 = {KN, 10'b1001000101};

	always #50 SYS_CLK = ~SYS_CLK;

	stp_tx_pcs i_dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TX_DATA(TX_DATA), .TX_KCTRL(TX_KCTRL),
		.TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_SERIAL(TX_SERIAL), .HS_CLK_EN(HS_CLK_EN),
		.RX_TRAIN_CLK(RX_TRAIN_CLK), .FABRIC_CLK(FABRIC_CLK), .PLL_LOCKED(PLL_LOCKED));
	stp_fabric_src i_src (.SYS_CLK(SYS_CLK), .SRST(SRST), .TX_DATA(TX_DATA), .TX_KCTRL(TX_KCTRL),
		.TX_VALID(TX_VALID), .TX_READY(TX_READY));

	// one line bit per clock while the serializer runs
	always @(posedge SYS_CLK) begin
		if (HS_CLK_EN === 1'b1)
			bq.push_back(TX_SERIAL);
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR    <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD   <= 1'b0;
		@(negedge SYS_CLK);
		d = REG_RDATA;
	endtask
	task automatic rst();
		@(posedge SYS_CLK);
		SRST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		SRST <= 1'b0;
		// one more edge so the source never sees the old reset after words are queued
		@(posedge SYS_CLK);
		bq.delete();
	endtask
	task automatic drain();
		for (int n = 0; n < 2000 && i_src.q_r.size() != 0; n++)
			@(posedge SYS_CLK);
		repeat (150) @(posedge SYS_CLK);
	endtask
	task automatic clocks();
		logic pf, pt;
		fr = 0;
		tr = 0;
		pf = FABRIC_CLK;
		pt = RX_TRAIN_CLK;
		repeat (200) begin
			@(negedge SYS_CLK);
			fr += (FABRIC_CLK && !pf);
			tr += (RX_TRAIN_CLK && !pt);
			pf = FABRIC_CLK;
			pt = RX_TRAIN_CLK;
		end
	endtask
	function automatic logic [31:0] cfg(input int en, dbl, byp, w10, pr, dis, pd, m);
		cfg = 32'h0;
		cfg[STP_CTRL_CHAN_EN] = en[0];
		cfg[STP_CTRL_DBL] = dbl[0];
		cfg[STP_CTRL_ENC_BYP] = byp[0];
		cfg[STP_CTRL_W10] = w10[0];
		cfg[STP_CTRL_PROTO +: 2] = pr[1:0];
		cfg[STP_CTRL_GIGE_DIS] = dis[0];
		cfg[STP_CTRL_PREDIV] = pd[0];
		cfg[STP_CTRL_MULT +: 5] = m[4:0];
	endfunction
	function automatic logic [9:0] r10(input logic [9:0] w);
		return {<<{w}};
	endfunction
	function automatic logic [7:0] r8(input logic [7:0] w);
		return {<<{w}};
	endfunction
	// pattern search anywhere in the captured line, so latency does not matter
	function automatic bit has(input logic [39:0] p, input int n);
		for (int i = 0; i + n <= bq.size(); i++) begin
			has = 1;
			for (int j = 0; j < n; j++)
				if (bq[i+j] !== p[n-1-j])
					has = 0;
			if (has)
				return 1;
		end
		return 0;
	endfunction
	function automatic logic [9:0] g10(input int i);
		for (int j = 0; j < 10; j++)
			g10[9-j] = bq[i+j];
	endfunction
	function automatic int runmax();
		int r = 1;
		runmax = 0;
		for (int i = 1; i < bq.size(); i++) begin
			r = (bq[i] === bq[i-1]) ? r + 1 : 1;
			if (r > runmax)
				runmax = r;
		end
	endfunction
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (2) @(posedge SYS_CLK);
		SRST <= 1'b0;
		rd(STP_OFS_CTRL, rv);
		chk(rv, 32'h0000_0a00, "ctrl reset");
		wr(4'h8, 32'hffff_ffff);
		rd(4'h8, rv);
		chk(rv, 32'h0, "unmapped read");
		rd(STP_OFS_CTRL, rv);
		chk(rv, 32'h0000_0a00, "unmapped write leaked");
		// every factor with and without the pre-divider
		foreach (ml[i])
			for (int p = 0; p < 2; p++) begin
				wr(STP_OFS_CTRL, cfg(1, 0, 0, 0, 0, 0, p, ml[i]));
				rd(STP_OFS_STAT, rv);
				chk(rv[STP_STAT_MULT_ERR], (ml[i] == 3 || (p == 0 && (ml[i] == 2 || ml[i] == 5))), "factor");
			end
		repeat (STP_LOCK_CYC + 5) @(posedge SYS_CLK);
		chk(PLL_LOCKED, 1, "lock pin");
		rd(STP_OFS_STAT, rv);
		chk(rv[STP_STAT_LOCK], 1, "lock status");
		wr(STP_OFS_CTRL, cfg(1, 0, 0, 0, 0, 0, 0, 5));
		repeat (STP_LOCK_CYC + 5) @(posedge SYS_CLK);
		chk(PLL_LOCKED, 0, "locked on bad factor");
		wr(STP_OFS_CTRL, cfg(0, 0, 0, 0, 0, 0, 0, 10));
		repeat (STP_LOCK_CYC + 5) @(posedge SYS_CLK);
		chk({PLL_LOCKED, HS_CLK_EN}, 0, "pll not off");
		// fifo fills while the channel is off, then drains in order
		rst();
		foreach (wd[i])
			i_src.put(20'(wd[i]), 2'b00);
		repeat (12) @(posedge SYS_CLK);
		chk(TX_READY, 0, "fifo not full");
		rd(STP_OFS_STAT, rv);
		chk(rv[STP_STAT_LEVEL +: 3], 4, "fifo level");
		wr(STP_OFS_CTRL, cfg(1, 0, 1, 1, 0, 0, 0, 10));
		drain();
		chk(has({r10(wd[0]), r10(wd[1]), r10(wd[2])}, 30), 1, "raw words");
		chk(has({r10(wd[3]), r10(wd[4]), r10(wd[5])}, 30), 1, "refilled words");
		clocks();
		chk((fr >= 19 && fr <= 21 && tr >= 19 && tr <= 21), 1, "single width clocks");
		rd(STP_OFS_STAT, rv);
		chk(rv[STP_STAT_UFLOW], 1, "underflow");
		wr(STP_OFS_CTRL, cfg(0, 0, 1, 1, 0, 0, 0, 10));
		wr(STP_OFS_STAT, 32'h1 << STP_STAT_UFLOW);
		rd(STP_OFS_STAT, rv);
		chk(rv[STP_STAT_UFLOW], 0, "underflow clear");
		// double width, low half leaves first
		rst();
		i_src.put({wd[1], wd[0]}, 2'b00);
		i_src.put({wd[3], wd[2]}, 2'b00);
		wr(STP_OFS_CTRL, cfg(1, 1, 1, 1, 0, 0, 0, 10));
		drain();
		chk(has({r10(wd[0]), r10(wd[1]), r10(wd[2]), r10(wd[3])}, 40), 1, "split order");
		clocks();
		chk((fr >= 9 && fr <= 11), 1, "double width fabric clock");
		// 8-bit raw single width
		rst();
		for (int i = 0; i < 3; i++)
			i_src.put(20'(wd[i][7:0]), 2'b00);
		wr(STP_OFS_CTRL, cfg(1, 0, 1, 0, 0, 0, 0, 10));
		drain();
		chk(has({r8(wd[0][7:0]), r8(wd[1][7:0]), r8(wd[2][7:0])}, 24), 1, "8-bit words");
		// gigabit idles, machine on and then statically off
		for (int d = 0; d < 2; d++) begin
			rst();
			foreach (gd[i])
				i_src.put(20'(gd[i]), {1'b0, gd[i] == 8'hbc});
			wr(STP_OFS_CTRL, cfg(1, 0, 0, 0, 1, d, 0, 10));
			drain();
			chk(runmax() <= 5, 1, "run length");
			if (d == 0) begin
				chk(has({I1, KN}, 30) || has({I2, KN}, 30), 1, "idle set");
				chk(has({KN, 10'b1010101010}, 20) || has({KP, 10'b1010101010}, 20), 1, "config set");
			end else begin
				chk(has(I1, 20) || has(I2, 20), 0, "idle remapped while off");
			end
		end
		// xaui: start, data, terminate, then idles from the filler
		rst();
		i_src.put(20'h000fb, 2'b01);
		i_src.put(20'h00055, 2'b00);
		i_src.put(20'h0009c, 2'b01);
		i_src.put(20'h00012, 2'b01);
		i_src.put(20'h000fd, 2'b01);
		wr(STP_OFS_CTRL, cfg(1, 0, 0, 0, 2, 0, 0, 10));
		drain();
		repeat (1000) @(posedge SYS_CLK);
		chk(has(10'b1101101000, 10) || has(10'b0010010111, 10), 1, "start");
		chk(has(10'b1010100101, 10), 1, "data");
		chk(has(10'b0011110010, 10) || has(10'b1100001101, 10), 1, "sequence");
		chk(has(10'b0111101000, 10) || has(10'b1000010111, 10), 1, "invalid to error");
		chk(has(10'b1011101000, 10) || has(10'b0100010111, 10), 1, "terminate");
		chk(runmax() <= 5, 1, "run length");
		// align on a comma group, then classify every later group
		st = -1;
		for (int i = 0; i + 10 <= bq.size() && st < 0; i++)
			if (g10(i) === KN || g10(i) === KP)
				st = i;
		gap = -1;
		ok = (st >= 0);
		na = 0;
		fr = 0;
		tr = 0;
		for (int i = st; st >= 0 && i + 10 <= bq.size(); i += 10) begin
			if (g10(i) === AN || g10(i) === AP) begin
				if (gap >= 0 && (gap < STP_A_MIN || gap > 31))
					ok = 0;
				gap = 0;
				na++;
			end else begin
				gap += (gap >= 0);
				fr += (g10(i) === RN || g10(i) === RP);
				tr += (g10(i) === KN || g10(i) === KP);
				if (!(g10(i) === RN || g10(i) === RP || g10(i) === KN || g10(i) === KP))
					ok = 0;
			end
		end
		chk(ok && na >= 2, 1, "idle column spacing");
		chk(fr > 0 && tr > 0, 1, "idle mix");
		stop_test();
	end

	// hang guard well above the few thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge SYS_CLK);
		num_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule

`default_nettype wire
